// ---- gpio_port.sv ----
`default_nettype none
// Operation
// RULE1: 21 pins: ports zero and one eight bits, port two five bits.
// RULE2: port data writable as whole byte or single bit.
// RULE3: function select bit 1 picks peripheral function per pin.
// RULE4: every pin is GPIO after reset.
// RULE5: pins default input; direction bit 1 makes output, changeable anytime.
// RULE6: inputs pull-up by default; input mode bit 1 removes pull.
// RULE7: GPIO inputs interrupt on rising or falling edge as selected.
// RULE8: one common interrupt enable per port.
// RULE9: port one has per-bit interrupt enables in its mask register.
// RULE10: port zero nibble enables; port two shares one enable.
// RULE11: edge control holds p0/p2 enables and edges; flag register per port.
// RULE12: all 21 pins interrupt and can wake from sleep.
// RULE13: transitions on port zero or one raise that port's DMA trigger.
// RULE14: only GPIO input transitions raise DMA triggers.
// RULE15: peripherals have two locations chosen by location control bits.
// RULE16: usart zero pin order at port zero or port one.
// RULE17: usart one pin order at port zero or port one high bits.
// RULE18: timer channels map to listed pins per location bit.
// RULE19: adc on port zero, crystal on p2 3/4, debug on p2 1/2.
// RULE20: edge sets flag always; stays until cleared; irq needs both enables.
// RULE21: analog config bit 1 makes port zero pin analog, overriding select.
module gpio_port
	import gpio_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [7:0] P0_IN,
	input wire logic [7:0] P1_IN,
	input wire logic [4:0] P2_IN,
	output logic [7:0] P0_OUT,
	output logic [7:0] P1_OUT,
	output logic [4:0] P2_OUT,
	output logic [7:0] P0_OE,
	output logic [7:0] P1_OE,
	output logic [4:0] P2_OE,
	output logic [7:0] P0_PULL_EN,
	output logic [7:0] P1_PULL_EN,
	output logic [4:0] P2_PULL_EN,
	output logic [7:0] P0_ANALOG,
	output logic [4:0] P2_ANALOG,
	input wire data_wr_s DATA_WR,
	output logic [7:0] P0_DATA,
	output logic [7:0] P1_DATA,
	output logic [4:0] P2_DATA,
	input wire port_cfg_s P0_CFG,
	input wire port_cfg_s P1_CFG,
	input wire port_cfg_s P2_CFG,
	input wire logic [7:0] ANALOG_INPUT_CONFIG,
	input wire logic [7:0] PERIPHERAL_LOCATION_CTRL,
	input wire logic [7:0] PIN_IRQ_EDGE_CONTROL,
	input wire logic [7:0] PORT_ONE_BIT_IRQ_ENABLE,
	input wire logic PORT_ZERO_COMMON_IRQ_EN,
	input wire logic PORT_ONE_COMMON_IRQ_EN,
	input wire logic PORT_TWO_COMMON_IRQ_EN,
	input wire logic XOSC_ON_PINS,
	input wire logic DEBUG_DRIVE,
	input wire logic DEBUG_DATA_OUT,
	input wire logic [7:0] FLAG0_CLR,
	input wire logic [7:0] FLAG1_CLR,
	input wire logic [4:0] FLAG2_CLR,
	output logic [7:0] PORT_ZERO_IRQ_FLAGS,
	output logic [7:0] PORT_ONE_IRQ_FLAGS,
	output logic [4:0] PORT_TWO_IRQ_FLAGS,
	output logic IRQ_P0,
	output logic IRQ_P1,
	output logic IRQ_P2,
	output logic WAKEUP,
	output logic PORT_ZERO_DMA_TRIGGER,
	output logic PORT_ONE_DMA_TRIGGER,
	input wire periph_out_s PERIPH_OUT,
	output logic U0_RX_IN,
	output logic U0_CTS_IN,
	output logic U1_RX_IN,
	output logic U1_CTS_IN,
	output logic [2:0] T1_IN,
	output logic [1:0] T3_IN,
	output logic [1:0] T4_IN,
	output logic DEBUG_DATA_IN,
	output logic DEBUG_CLOCK_IN
);
	logic [7:0] d0_q;
	logic [7:0] d1_q;
	logic [4:0] d2_q;
	logic [7:0] f0_q;
	logic [7:0] f1_q;
	logic [4:0] f2_q;
	logic [7:0] s0, s1, e0, e1, t0, t1, pu0, pu1;
	logic [4:0] s2, e2, t2, pu2;
	logic [7:0] sel0_eff;
	logic [7:0] po0, po1, oe0, oe1;
	logic [4:0] po2, oe2;

	assign sel0_eff = P0_CFG.sel & ~ANALOG_INPUT_CONFIG; // [RULE21]

	// RULE1: ports of eight, eight and five bits
	gpio_pin_ctl #(.W(PORT_W)) u_p0 (.clk(CLK), .reset(RESET), .pin_in(P0_IN),
		.sel(sel0_eff | ANALOG_INPUT_CONFIG), .dir(P0_CFG.dir), .inp(P0_CFG.inp),
		.falling(PIN_IRQ_EDGE_CONTROL[EDGE_P0]), .sync_in(s0), .edge_hit(e0), .any_trans(t0),
		.pull_en(pu0)); // [RULE1]
	gpio_pin_ctl #(.W(PORT_W)) u_p1 (.clk(CLK), .reset(RESET), .pin_in(P1_IN),
		.sel(P1_CFG.sel), .dir(P1_CFG.dir), .inp(P1_CFG.inp),
		.falling(PIN_IRQ_EDGE_CONTROL[EDGE_P1]), .sync_in(s1), .edge_hit(e1), .any_trans(t1),
		.pull_en(pu1));
	gpio_pin_ctl #(.W(PORT2_W)) u_p2 (.clk(CLK), .reset(RESET), .pin_in(P2_IN),
		.sel(P2_CFG.sel[4:0]), .dir(P2_CFG.dir[4:0]), .inp(P2_CFG.inp[4:0]),
		.falling(PIN_IRQ_EDGE_CONTROL[EDGE_P2]), .sync_in(s2), .edge_hit(e2), .any_trans(t2),
		.pull_en(pu2));

	// cpu data registers, byte or bit writes
	always_ff @(posedge CLK) begin
		if (RESET) begin
			d0_q <= DATA_RST;
			d1_q <= DATA_RST;
			d2_q <= DATA_RST[4:0];
		end else if (DATA_WR.kind == WR_BYTE) begin
			if (DATA_WR.port == 2'd0) d0_q <= DATA_WR.data; // [RULE2]
			else if (DATA_WR.port == 2'd1) d1_q <= DATA_WR.data;
			else if (DATA_WR.port == 2'd2) d2_q <= DATA_WR.data[4:0];
		end else if (DATA_WR.kind == WR_BIT) begin
			if (DATA_WR.port == 2'd0) d0_q[DATA_WR.bit_idx] <= DATA_WR.data[0]; // [RULE2]
			else if (DATA_WR.port == 2'd1) d1_q[DATA_WR.bit_idx] <= DATA_WR.data[0];
			else if (DATA_WR.port == 2'd2 && DATA_WR.bit_idx < 3'd5) d2_q[DATA_WR.bit_idx] <= DATA_WR.data[0];
		end
	end

	// peripheral output muxing; gpio where select bit is 0
	always_comb begin
		po0 = d0_q;
		po1 = d1_q;
		po2 = d2_q;
		oe0 = P0_CFG.dir & ~ANALOG_INPUT_CONFIG; // [RULE5]
		oe1 = P1_CFG.dir;
		oe2 = P2_CFG.dir[4:0];
		// timer1 [RULE18]
		if (!PERIPHERAL_LOCATION_CTRL[LOC_T1]) begin
			if (sel0_eff[2]) po0[2] = PERIPH_OUT.t1[0];
			if (sel0_eff[3]) po0[3] = PERIPH_OUT.t1[1];
			if (sel0_eff[4]) po0[4] = PERIPH_OUT.t1[2];
		end else begin
			if (P1_CFG.sel[2]) po1[2] = PERIPH_OUT.t1[0];
			if (P1_CFG.sel[1]) po1[1] = PERIPH_OUT.t1[1];
			if (P1_CFG.sel[0]) po1[0] = PERIPH_OUT.t1[2];
		end
		if (!PERIPHERAL_LOCATION_CTRL[LOC_T3]) begin
			if (P1_CFG.sel[3]) po1[3] = PERIPH_OUT.t3[0];
			if (P1_CFG.sel[4]) po1[4] = PERIPH_OUT.t3[1];
		end else begin
			if (P1_CFG.sel[6]) po1[6] = PERIPH_OUT.t3[0];
			if (P1_CFG.sel[7]) po1[7] = PERIPH_OUT.t3[1];
		end
		if (!PERIPHERAL_LOCATION_CTRL[LOC_T4]) begin
			if (P1_CFG.sel[0]) po1[0] = PERIPH_OUT.t4[0];
			if (P1_CFG.sel[1]) po1[1] = PERIPH_OUT.t4[1];
		end else begin
			if (P2_CFG.sel[0]) po2[0] = PERIPH_OUT.t4[0];
			if (P2_CFG.sel[3]) po2[3] = PERIPH_OUT.t4[1];
		end
		// usart1: rx,tx,rts,cts at bits 5,4,3,2 or 7,6,5,4 [RULE17]
		if (!PERIPHERAL_LOCATION_CTRL[LOC_U1]) begin
			if (sel0_eff[4]) po0[4] = PERIPH_OUT.u1_tx;
			if (sel0_eff[3]) po0[3] = PERIPH_OUT.u1_rts;
		end else begin
			if (P1_CFG.sel[6]) po1[6] = PERIPH_OUT.u1_tx;
			if (P1_CFG.sel[5]) po1[5] = PERIPH_OUT.u1_rts;
		end
		// usart0 has top precedence, applied last [RULE16]
		if (!PERIPHERAL_LOCATION_CTRL[LOC_U0]) begin
			if (sel0_eff[3]) po0[3] = PERIPH_OUT.u0_tx;
			if (sel0_eff[5]) po0[5] = PERIPH_OUT.u0_rts;
		end else begin
			if (P1_CFG.sel[5]) po1[5] = PERIPH_OUT.u0_tx;
			if (P1_CFG.sel[3]) po1[3] = PERIPH_OUT.u0_rts;
		end
		// crystal pins go analog and undriven [RULE19]
		if (XOSC_ON_PINS) begin
			oe2[3] = 1'b0;
			oe2[4] = 1'b0;
		end
		// debug data overrides select and direction
		if (DEBUG_DRIVE) begin
			po2[1] = DEBUG_DATA_OUT; // [RULE19]
			oe2[1] = 1'b1;
		end
	end

	// interrupt flags: set wins over clear, enables ignored [RULE20]
	always_ff @(posedge CLK) begin
		if (RESET) begin
			f0_q <= '0;
			f1_q <= '0;
			f2_q <= '0;
		end else begin
			f0_q <= (f0_q & ~FLAG0_CLR) | e0; // [RULE7]
			f1_q <= (f1_q & ~FLAG1_CLR) | e1;
			f2_q <= (f2_q & ~FLAG2_CLR) | e2; // [RULE12]
		end
	end

	// pin outputs and requests, registered
	always_ff @(posedge CLK) begin
		if (RESET) begin
			P0_OUT <= '0;
			P1_OUT <= '0;
			P2_OUT <= '0;
			P0_OE <= '0; // [RULE4] [RULE5]
			P1_OE <= '0;
			P2_OE <= '0;
			P0_PULL_EN <= '1; // [RULE6]
			P1_PULL_EN <= '1;
			P2_PULL_EN <= '1;
			P0_ANALOG <= '0;
			P2_ANALOG <= '0;
			IRQ_P0 <= 1'b0;
			IRQ_P1 <= 1'b0;
			IRQ_P2 <= 1'b0;
			WAKEUP <= 1'b0;
			PORT_ZERO_DMA_TRIGGER <= 1'b0;
			PORT_ONE_DMA_TRIGGER <= 1'b0;
		end else begin
			P0_OUT <= po0;
			P1_OUT <= po1;
			P2_OUT <= po2;
			P0_OE <= oe0; // [RULE3]
			P1_OE <= oe1;
			P2_OE <= oe2;
			P0_PULL_EN <= pu0 & ~ANALOG_INPUT_CONFIG;
			P1_PULL_EN <= pu1;
			P2_PULL_EN <= pu2 & ~{XOSC_ON_PINS, XOSC_ON_PINS, 3'b000};
			P0_ANALOG <= ANALOG_INPUT_CONFIG; // [RULE21]
			P2_ANALOG <= {XOSC_ON_PINS, XOSC_ON_PINS, 3'b000};
			// [RULE8] [RULE10] [RULE11]
			IRQ_P0 <= PORT_ZERO_COMMON_IRQ_EN &&
				((|f0_q[3:0] && PIN_IRQ_EDGE_CONTROL[EN_P0_LO]) || (|f0_q[7:4] && PIN_IRQ_EDGE_CONTROL[EN_P0_HI]));
			IRQ_P1 <= PORT_ONE_COMMON_IRQ_EN && |(f1_q & PORT_ONE_BIT_IRQ_ENABLE); // [RULE9]
			IRQ_P2 <= PORT_TWO_COMMON_IRQ_EN && PIN_IRQ_EDGE_CONTROL[EN_P2] && |f2_q; // [RULE10]
			// wake needs no clock gating decisions here; power control latches it
			WAKEUP <= |{e0, e1, e2}; // [RULE12]
			PORT_ZERO_DMA_TRIGGER <= |t0; // [RULE13] [RULE14]
			PORT_ONE_DMA_TRIGGER <= |t1;
		end
	end

	// peripheral inputs from synchronised pins [RULE15]
	always_ff @(posedge CLK) begin
		if (RESET) begin
			U0_RX_IN <= 1'b1;
			U0_CTS_IN <= 1'b1;
			U1_RX_IN <= 1'b1;
			U1_CTS_IN <= 1'b1;
			T1_IN <= '0;
			T3_IN <= '0;
			T4_IN <= '0;
			DEBUG_DATA_IN <= 1'b0;
			DEBUG_CLOCK_IN <= 1'b0;
		end else begin
			U0_RX_IN <= PERIPHERAL_LOCATION_CTRL[LOC_U0] ? s1[4] : s0[2]; // [RULE16]
			U0_CTS_IN <= PERIPHERAL_LOCATION_CTRL[LOC_U0] ? s1[2] : s0[4];
			U1_RX_IN <= PERIPHERAL_LOCATION_CTRL[LOC_U1] ? s1[7] : s0[5]; // [RULE17]
			U1_CTS_IN <= PERIPHERAL_LOCATION_CTRL[LOC_U1] ? s1[4] : s0[2];
			T1_IN <= PERIPHERAL_LOCATION_CTRL[LOC_T1] ? {s1[0], s1[1], s1[2]} : s0[4:2]; // [RULE18]
			T3_IN <= PERIPHERAL_LOCATION_CTRL[LOC_T3] ? s1[7:6] : s1[4:3];
			T4_IN <= PERIPHERAL_LOCATION_CTRL[LOC_T4] ? {s2[3], s2[0]} : s1[1:0];
			DEBUG_DATA_IN <= s2[1]; // [RULE19]
			DEBUG_CLOCK_IN <= s2[2];
		end
	end

	assign P0_DATA = d0_q;
	assign P1_DATA = d1_q;
	assign P2_DATA = d2_q;
	assign PORT_ZERO_IRQ_FLAGS = f0_q; // [RULE11]
	assign PORT_ONE_IRQ_FLAGS = f1_q;
	assign PORT_TWO_IRQ_FLAGS = f2_q;
endmodule
`default_nettype wire

// ---- gpio_pkg.sv ----
`default_nettype none
package gpio_pkg;
	localparam int PORT_W = 8;
	localparam int PORT2_W = 5;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] SEL_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] INP_RST = 8'h00;
	localparam logic [7:0] ADC_RST = 8'h00;
	localparam logic [7:0] LOC_RST = 8'h00;
	localparam logic [7:0] EDGE_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	// edge control bit positions
	localparam int EDGE_P0 = 0;
	localparam int EDGE_P1 = 1;
	localparam int EDGE_P2 = 2;
	localparam int EN_P0_LO = 3;
	localparam int EN_P0_HI = 4;
	localparam int EN_P2 = 5;
	// location control bit positions
	localparam int LOC_U0 = 0;
	localparam int LOC_U1 = 1;
	localparam int LOC_T4 = 4;
	localparam int LOC_T3 = 5;
	localparam int LOC_T1 = 6;
	// sfr write from cpu: whole byte or one bit
	typedef enum logic [1:0] {WR_NONE = 2'b00, WR_BYTE = 2'b01, WR_BIT = 2'b11} wr_kind_e;
	typedef struct packed {
		wr_kind_e kind;
		logic [1:0] port;
		logic [2:0] bit_idx;
		logic [7:0] data;
	} data_wr_s;
	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] dir;
		logic [7:0] inp;
	} port_cfg_s;
	typedef struct packed {
		logic u0_rx, u0_tx, u0_cts, u0_rts;
		logic u1_rx, u1_tx, u1_cts, u1_rts;
		logic [2:0] t1;
		logic [1:0] t3;
		logic [1:0] t4;
	} periph_out_s;
endpackage
`default_nettype wire

// ---- gpio_pin_ctl.sv ----
`default_nettype none
// one port: direction, pull and edge sense
module gpio_pin_ctl
	import gpio_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] pin_in,
	input wire logic [W-1:0] sel,
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] inp,
	input wire logic falling,
	output logic [W-1:0] sync_in,
	output logic [W-1:0] edge_hit,
	output logic [W-1:0] any_trans,
	output logic [W-1:0] pull_en
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			wire gp_in = !sel[i] && !dir[i];
			assign any_trans[i] = gp_in && (sync_q[i] ^ prev_q[i]); // [RULE14]
			assign edge_hit[i] = gp_in && (falling ? (prev_q[i] && !sync_q[i]) : (!prev_q[i] && sync_q[i])); // [RULE7]
			assign pull_en[i] = !inp[i] && !dir[i] && !sel[i]; // [RULE6]
		end
	endgenerate
	assign sync_in = sync_q;
endmodule
`default_nettype wire

// ---- gpio_port_assertions.sv ----
`default_nettype none
module gpio_port_checker
	import gpio_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET,
	input wire logic [7:0] P1_IN,
	input wire logic [7:0] P1_OE,
	input wire logic [7:0] P1_PULL_EN,
	input wire logic [7:0] P0_ANALOG,
	input wire data_wr_s DATA_WR,
	input wire logic [7:0] P1_DATA,
	input wire port_cfg_s P1_CFG,
	input wire logic [7:0] ANALOG_INPUT_CONFIG,
	input wire logic [7:0] PORT_ONE_BIT_IRQ_ENABLE,
	input wire logic PORT_ONE_COMMON_IRQ_EN,
	input wire logic [7:0] FLAG1_CLR,
	input wire logic [7:0] PORT_ONE_IRQ_FLAGS,
	input wire logic IRQ_P1,
	input wire logic PORT_ONE_DMA_TRIGGER
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	port_cfg_s cfg_q;
	logic hit_q;
	// outputs are registered, so compare with last cycle's config
	always_ff @(posedge CLK) begin
		cfg_q <= P1_CFG;
	end
	always_ff @(posedge CLK) begin
		hit_q <= PORT_ONE_COMMON_IRQ_EN && |(PORT_ONE_IRQ_FLAGS & PORT_ONE_BIT_IRQ_ENABLE);
	end
	a_reset_idle: assert property ($past(RESET) |-> P1_OE == 8'h00 && P1_PULL_EN == 8'hFF)
		else $error("not idle after reset");
	a_oe_dir: assert property (!$past(RESET) |-> ((P1_OE ^ cfg_q.dir) & ~cfg_q.sel) == 8'h00)
		else $error("oe wrong");
	a_pull_input: assert property (!$past(RESET) |-> P1_PULL_EN == (~cfg_q.sel & ~cfg_q.dir & ~cfg_q.inp))
		else $error("pull wrong");
	a_analog_sel: assert property (!$past(RESET) |-> P0_ANALOG == $past(ANALOG_INPUT_CONFIG))
		else $error("analog wrong");
	a_byte_write: assert property (DATA_WR.kind == WR_BYTE && DATA_WR.port == 2'h1
		|=> P1_DATA == $past(DATA_WR.data)) else $error("write lost");
	a_flag_sticky: assert property (!$past(RESET)
		|-> ($past(PORT_ONE_IRQ_FLAGS) & ~$past(FLAG1_CLR) & ~PORT_ONE_IRQ_FLAGS) == 8'h00) else $error("flag lost");
	a_irq_gate: assert property (IRQ_P1 == hit_q)
		else $error("irq gate wrong");
	a_dma_change: assert property (PORT_ONE_DMA_TRIGGER |-> $past(P1_IN, 3) != $past(P1_IN, 4))
		else $error("dma without change");
endmodule
bind gpio_port gpio_port_checker chk (.*);
`default_nettype wire

// ---- gpio_pin_partner.sv ----
`default_nettype none
module gpio_pin_partner (
	input wire logic clk,
	input wire logic [20:0] oe,
	input wire logic [20:0] drv,
	input wire logic [20:0] pull,
	input wire logic [20:0] ext_en,
	input wire logic [20:0] ext_val,
	output logic [20:0] pin
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [20:0] float_q = 21'h0;
	// a floating line must never look stable
	always @(posedge clk) begin
		float_q <= ~float_q;
	end
	// outside driver wins over the pad, then the pull-up
	assign pin = (ext_en & ext_val) | (~ext_en & oe & drv) | (~ext_en & ~oe & (pull | float_q));
endmodule
`default_nettype wire

// ---- test_gpio_port.sv ----
`default_nettype none
module test_gpio_port
	import gpio_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	wire logic [7:0] P0_IN, P1_IN;
	wire logic [4:0] P2_IN;
	logic [7:0] P0_OUT, P1_OUT, P0_OE, P1_OE, P0_PULL_EN, P1_PULL_EN, P0_ANALOG, P0_DATA, P1_DATA;
	logic [4:0] P2_OUT, P2_OE, P2_PULL_EN, P2_ANALOG, P2_DATA, PORT_TWO_IRQ_FLAGS, FLAG2_CLR;
	logic [7:0] ANALOG_INPUT_CONFIG, PERIPHERAL_LOCATION_CTRL, PIN_IRQ_EDGE_CONTROL, PORT_ONE_BIT_IRQ_ENABLE;
	logic [7:0] FLAG0_CLR, FLAG1_CLR, PORT_ZERO_IRQ_FLAGS, PORT_ONE_IRQ_FLAGS;
	logic PORT_ZERO_COMMON_IRQ_EN, PORT_ONE_COMMON_IRQ_EN, PORT_TWO_COMMON_IRQ_EN, XOSC_ON_PINS, DEBUG_DRIVE;
	logic DEBUG_DATA_OUT, IRQ_P0, IRQ_P1, IRQ_P2, WAKEUP, PORT_ZERO_DMA_TRIGGER, PORT_ONE_DMA_TRIGGER;
	logic U0_RX_IN, U0_CTS_IN, U1_RX_IN, U1_CTS_IN, DEBUG_DATA_IN, DEBUG_CLOCK_IN;
	logic [2:0] T1_IN;
	logic [1:0] T3_IN, T4_IN;
	data_wr_s DATA_WR;
	port_cfg_s P0_CFG, P1_CFG, P2_CFG;
	periph_out_s PERIPH_OUT;
	logic [20:0] ext_en, ext_val;
	int n_errors, total_checks, n0, n1, nw;
	gpio_port dut (.*);
	gpio_pin_partner far (.clk(CLK), .oe({P2_OE, P1_OE, P0_OE}), .drv({P2_OUT, P1_OUT, P0_OUT}),
		.pull({P2_PULL_EN, P1_PULL_EN, P0_PULL_EN}), .ext_en(ext_en), .ext_val(ext_val), .pin({P2_IN, P1_IN, P0_IN}));
	initial begin
		forever #2 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		n0 += (PORT_ZERO_DMA_TRIGGER === 1'b1);
		n1 += (PORT_ONE_DMA_TRIGGER === 1'b1);
		nw += (WAKEUP === 1'b1);
	end
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_write;
		chk({3'h0, P2_PULL_EN}, 8'h1F);
		ext_en[15:8] = 8'h00;
		P1_CFG.dir = 8'hFF;
		DATA_WR = '{WR_BYTE, 2'h1, 3'h0, 8'hA5};
		tick(1);
		DATA_WR = '{WR_BIT, 2'h0, 3'h7, 8'h01};
		tick(1);
		// bit 6 of port two does not exist
		DATA_WR = '{WR_BIT, 2'h2, 3'h6, 8'h01};
		tick(1);
		DATA_WR.kind = WR_NONE;
		tick(6);
		chk(P1_OUT, 8'hA5);
		chk(P0_DATA, 8'h80);
		chk({3'h0, P2_DATA}, 8'h00);
		chk(n1[7:0], 8'h00);
		P1_CFG.dir = 8'h00;
		ext_en[15:8] = 8'hFF;
		tick(6);
		FLAG1_CLR = 8'hFF;
		tick(1);
		FLAG1_CLR = 8'h00;
		n1 = 0;
		$display("write done");
	endtask
	task automatic t_irq;
		PORT_ONE_BIT_IRQ_ENABLE = 8'h04;
		PORT_ONE_COMMON_IRQ_EN = 1'b1;
		ext_val[11:10] = 2'h0;
		tick(6);
		chk(PORT_ONE_IRQ_FLAGS, 8'h00);
		chk(n1[7:0], 8'h01);
		ext_val[11:10] = 2'h3;
		tick(6);
		chk(PORT_ONE_IRQ_FLAGS, 8'h0C);
		chk(IRQ_P1, 1'b1);
		FLAG1_CLR = 8'h04;
		tick(1);
		FLAG1_CLR = 8'h00;
		PORT_ONE_BIT_IRQ_ENABLE = 8'h08;
		PORT_ONE_COMMON_IRQ_EN = 1'b0;
		tick(3);
		chk(PORT_ONE_IRQ_FLAGS, 8'h08);
		chk(IRQ_P1, 1'b0);
		PIN_IRQ_EDGE_CONTROL[EDGE_P1] = 1'b1;
		ext_val[13] = 1'b0;
		tick(6);
		chk(PORT_ONE_IRQ_FLAGS, 8'h28);
		$display("irq done");
	endtask
	task automatic t_p0p2;
		// falling edges everywhere, p0 high nibble and p2 enabled
		PIN_IRQ_EDGE_CONTROL = 8'h37;
		PORT_ZERO_COMMON_IRQ_EN = 1'b1;
		PORT_TWO_COMMON_IRQ_EN = 1'b1;
		P2_CFG.inp = 5'h01;
		ext_val[1] = 1'b0;
		tick(6);
		chk(PORT_ZERO_IRQ_FLAGS, 8'h02);
		chk(IRQ_P0, 1'b0);
		ext_val[6] = 1'b0;
		ext_val[20] = 1'b0;
		tick(6);
		chk(IRQ_P0, 1'b1);
		chk({3'h0, PORT_TWO_IRQ_FLAGS}, 8'h10);
		chk(IRQ_P2, 1'b1);
		chk(n0[7:0], 8'h02);
		$display("p0p2 done");
	endtask
	task automatic t_periph;
		P0_CFG.sel = 8'h0C;
		P0_CFG.dir = 8'h08;
		ext_en[3] = 1'b0;
		PERIPH_OUT.u0_tx = 1'b1;
		ext_val[2] = 1'b0;
		tick(6);
		chk(P0_OUT[3], 1'b1);
		chk(U0_RX_IN, 1'b0);
		PERIPHERAL_LOCATION_CTRL[LOC_U0] = 1'b1;
		P1_CFG.sel = 8'h30;
		PERIPH_OUT.u0_tx = 1'b0;
		tick(6);
		chk(P1_OUT[5], 1'b0);
		chk(U0_RX_IN, 1'b1);
		ANALOG_INPUT_CONFIG = 8'h80;
		ext_val[7] = 1'b0;
		tick(6);
		chk(P0_ANALOG, 8'h80);
		chk(n0[7:0], 8'h02);
		$display("periph done");
	endtask
	task automatic t_misc;
		// crystal and debug overrides on port two, timer4 at its second location
		nw = 0;
		XOSC_ON_PINS = 1'b1;
		DEBUG_DRIVE = 1'b1;
		DEBUG_DATA_OUT = 1'b1;
		PERIPHERAL_LOCATION_CTRL[LOC_T4] = 1'b1;
		ext_val[16] = 1'b0;
		tick(6);
		chk({3'h0, P2_ANALOG}, 8'h18);
		chk({3'h0, P2_OE}, 8'h02);
		chk({3'h0, P2_OUT}, 8'h02);
		chk({3'h0, P2_PULL_EN}, 8'h06);
		chk({6'h00, T4_IN}, 8'h02);
		chk({6'h00, DEBUG_CLOCK_IN, DEBUG_DATA_IN}, 8'h03);
		chk({3'h0, PORT_TWO_IRQ_FLAGS}, 8'h11);
		chk(nw[7:0], 8'h01);
		$display("misc done");
	endtask
	initial begin
		#100000;
		n_errors++;
		report_and_stop;
	end
	initial begin
		ext_en = 21'h1FFFFF;
		ext_val = 21'h1FFFFF;
		DATA_WR = '{WR_NONE, 2'h0, 3'h0, 8'h00};
		P0_CFG = 24'h000000;
		P1_CFG = 24'h000000;
		P2_CFG = 24'h000000;
		PERIPH_OUT = 15'h0000;
		{ANALOG_INPUT_CONFIG, PERIPHERAL_LOCATION_CTRL, PIN_IRQ_EDGE_CONTROL, PORT_ONE_BIT_IRQ_ENABLE} = 32'h00000000;
		{FLAG0_CLR, FLAG1_CLR, FLAG2_CLR} = 21'h000000;
		{PORT_ZERO_COMMON_IRQ_EN, PORT_ONE_COMMON_IRQ_EN, PORT_TWO_COMMON_IRQ_EN} = 3'h0;
		{XOSC_ON_PINS, DEBUG_DRIVE, DEBUG_DATA_OUT} = 3'h0;
		tick(12);
		RESET = 1'b0;
		tick(1);
		t_write;
		t_irq;
		t_p0p2;
		t_periph;
		t_misc;
		report_and_stop;
	end
endmodule
`default_nettype wire
